// ### hw/rx_marker_pkg.sv
// constants and types shared by the receive marker and link output block
package rx_marker_pkg;

  // ==========================================================
  // bus geometry
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;

  // ==========================================================
  // register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_FRAC = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_CLEAR = 5'h0C;
  localparam logic [4:0] OFS_ENABLE = 5'h10;
  localparam logic [4:0] OFS_STATE = 5'h14;

  // ==========================================================
  // control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_HDLC_EN = 2;
  localparam int unsigned CTRL_FRAC_EN = 3;
  localparam int unsigned CTRL_LTSEL = 4;
  localparam int unsigned CTRL_SIGMF_EN = 5;
  localparam int unsigned CTRL_CRCMF_EN = 6;
  localparam int unsigned CTRL_SRC_TS16 = 7;
  localparam int unsigned CTRL_NAT_LSB = 8;
  localparam int unsigned CTRL_W = 13;
  localparam logic [12:0] CTRL_RESET = 13'h0080;
  localparam logic [31:0] FRAC_RESET = 32'h0000_0000;

  // ==========================================================
  // interrupt events
  localparam int unsigned EV_MARKER = 0;
  localparam int unsigned EV_HDLC = 1;
  localparam int unsigned EV_EOM = 2;
  localparam int unsigned EV_W = 3;
  localparam logic [2:0] EV_RESET = 3'h0;

  // ==========================================================
  // frame geometry: 256 bits, 32 timeslots, 16-frame multiframes
  localparam logic [7:0] BIT_FIRST = 8'h00;
  localparam logic [7:0] BIT_STEP = 8'h01;
  localparam logic [3:0] FRM_FIRST = 4'h0;
  localparam logic [3:0] FRM_STEP = 4'h1;
  localparam logic [4:0] DL_TIMESLOT = 5'h10;
  localparam logic [4:0] TS_ZERO = 5'h00;
  localparam logic [2:0] NAT_FIRST_BIT = 3'h3;

  // marker modes
  typedef enum logic [1:0] {
    MARK_FRAME = 2'b00,
    MARK_SIG_MF = 2'b01,
    MARK_CRC_MF = 2'b10,
    MARK_COMPOSITE = 2'b11
  } marker_mode_e;

endpackage : rx_marker_pkg

// ### hw/edge_sync.sv
// two-flop synchroniser with edge detection for an outside level
`timescale 1ns/1ps
`default_nettype none

module edge_sync
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // ==========================================================
  // next state: meta feeds only sync
  always_comb
  begin
    s_d.meta = async_i;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // edges seen between second and third flop
  assign level_o = s_q.sync;
  assign rise_o = s_q.sync & ~s_q.prev;
  assign fall_o = ~s_q.sync & s_q.prev;

endmodule : edge_sync

`default_nettype wire

// ### hw/event_irq.sv
// sticky event status, enable mask and level interrupt
`timescale 1ns/1ps
`default_nettype none

module event_irq
  import rx_marker_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [EV_W-1:0] event_i,
  input wire logic clear_we_i,
  input wire logic [EV_W-1:0] clear_i,
  input wire logic enable_we_i,
  input wire logic [EV_W-1:0] enable_i,
  output logic [EV_W-1:0] status_o,
  output logic [EV_W-1:0] enable_o,
  output logic irq_o
);

  typedef struct packed {
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] enable;
    logic irq;
  } irq_s;

  irq_s s_q;
  irq_s s_d;

  // ==========================================================
  // a set in the clearing cycle wins over the clear
  always_comb
  begin
    s_d = s_q;
    if (clear_we_i)
      s_d.status = s_q.status & ~clear_i;
    s_d.status = s_d.status | event_i;
    if (enable_we_i)
      s_d.enable = enable_i;
    s_d.irq = |(s_d.status & s_d.enable);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      s_q.status <= EV_RESET;
      s_q.enable <= EV_RESET;
      s_q.irq <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  assign status_o = s_q.status;
  assign enable_o = s_q.enable;
  assign irq_o = s_q.irq;

endmodule : event_irq

`default_nettype wire

// ### hw/rx_marker_link.sv
// receive frame marker, data link and link status outputs of one channel
//
// What this block does
// - frame mode: marker high one line-clock cycle on bit 1 of each frame
// - signaling mode: one-cycle pulse on bit 1, frame 1 of signaling multiframe
// - signaling multiframing off: marker still pulses every sixteenth frame
// - CRC mode: one-cycle pulse on bit 1, frame 1 of CRC multiframe
// - CRC multiframing off: marker still marks bit 1 every sixteenth frame
// - composite: rise at signaling frame-1 start, fall after CRC frame-1 bit 1
// - composite with coincident boundaries: single one-cycle pulse each 16 frames
// - marker updates on the falling edge of the recovered line clock
// - link data and clock shown only with HDLC off or fractional mode on
// - link source is timeslot 16, a chosen set of national bits, or masked timeslots in fractional mode
// - link data changes on the falling edge of the link clock
// - with HDLC on and fractional mode off, shared pins carry receiver interrupt and message end
// - receiver interrupt goes high on any HDLC receiver status event
// - message end goes high on last byte read or FIFO overrun
// - recovered line clock output follows the 2.048 MHz line clock
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// notes for the next engineer
// - one channel only; instantiate four for a quad framer
// - the line clock pin is sampled, so every line output lags the pin
//   by two to three bus clocks; the recovered clock copy lags the same
// - marker, link data and the falling link clock change in the same bus clock
//   in which the recovered clock copy falls, and the link clock rises with the copy, so they keep their phase
// - the marker is still driven while line-timing select is set;
//   outside logic must not trust it then
// - frame and multiframe counts free-run when no alignment is given,
//   so the marker keeps its sixteen-frame rhythm without framing
// - the frame-alignment frame is taken as an even crc frame count
// - the shared pins switch source with the control register at once;
//   a half-finished link bit may be cut when software flips hdlc enable
// - the bus always answers after exactly one wait state
//
// register map
//   0x00 control: mode, hdlc enable, fractional enable, line-timing select,
//        multiframe enables, timeslot-16 source, national-bit mask
//   0x04 fractional timeslot mask, one bit per timeslot
//   0x08 sticky status, read only: marker rise, hdlc event, message end
//   0x0c write one to clear status bits
//   0x10 interrupt enable, same layout as status
//   0x14 live position: bit, signaling frame, crc frame, marker
//   other offsets read zero and ignore writes

module rx_marker_link
  import rx_marker_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  // recovered line clock pin, outside domain
  input wire logic line_clock_i,
  // framer alignment, valid in the falling-edge cycle
  input wire logic frame_align_i,
  input wire logic sig_mf_align_i,
  input wire logic crc_mf_align_i,
  input wire logic line_bit_i,
  // hdlc receive unit status
  input wire logic hdlc_status_event_i,
  input wire logic hdlc_irq_ack_i,
  input wire logic hdlc_last_byte_read_i,
  input wire logic hdlc_overrun_i,
  // outputs
  output logic recovered_line_clock_o,
  output logic receive_frame_marker_o,
  output logic link_serial_out_o,
  output logic link_clock_out_o,
  output logic line_timing_output_select_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] bit_cnt;
    logic [3:0] sig_frm;
    logic [3:0] crc_frm;
    logic marker;
    logic crc_prev;
    logic line_clk;
    logic link_data;
    logic link_clk;
    logic dl_irq;
    logic eom;
    logic pin_a;
    logic pin_b;
    logic [CTRL_W-1:0] ctrl;
    logic [31:0] frac;
    logic ack;
    logic [31:0] rdata;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic lclk_lvl;
  logic lclk_rise;
  logic lclk_fall;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] ev_status;
  logic [EV_W-1:0] ev_enable;
  logic ev_irq;
  logic clear_we;
  logic enable_we;
  // lclk_*: synchronised line clock level and its edges
  // ev: one-cycle event strobes into the sticky status
  // clear_we, enable_we: register writes that hit the interrupt block

  // ==========================================================
  // helpers
  // byte-lane merge for a register write
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : merge_be

  // is this bit position part of the extracted data link
  function automatic logic link_bit_sel(input logic [7:0] pos, input logic fas, input logic ts16,
                                        input logic [4:0] nat);
    logic r;
    r = 1'b0;
    if (ts16)
      r = (pos[7:3] == DL_TIMESLOT);
    else if (!fas && pos[7:3] == TS_ZERO && pos[2:0] >= NAT_FIRST_BIT)
      r = nat[3'(pos[2:0] - NAT_FIRST_BIT)];
    return r;
  endfunction : link_bit_sel

  // ==========================================================
  // line clock synchroniser
  edge_sync u_lclk_sync
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(line_clock_i),
    .level_o(lclk_lvl),
    .rise_o(lclk_rise),
    .fall_o(lclk_fall)
  );

  // ==========================================================
  // interrupt status
  assign clear_we = s_q.ack && avs_write_i && avs_address_i == OFS_CLEAR && avs_byteenable_i[0];
  assign enable_we = s_q.ack && avs_write_i && avs_address_i == OFS_ENABLE && avs_byteenable_i[0];

  event_irq u_irq
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .event_i(ev),
    .clear_we_i(clear_we),
    .clear_i(avs_writedata_i[EV_W-1:0]),
    .enable_we_i(enable_we),
    .enable_i(avs_writedata_i[EV_W-1:0]),
    .status_o(ev_status),
    .enable_o(ev_enable),
    .irq_o(ev_irq)
  );

  // ==========================================================
  // next-state logic
  always_comb
  begin
    logic [7:0] bit_nx;
    logic [3:0] sig_nx;
    logic [3:0] crc_nx;
    logic frame_start;
    logic sig_start;
    logic crc_start;
    logic sel;
    logic show_link;
    marker_mode_e mode;
    bit_nx = s_q.bit_cnt;
    sig_nx = s_q.sig_frm;
    crc_nx = s_q.crc_frm;
    frame_start = 1'b0;
    sig_start = 1'b0;
    crc_start = 1'b0;
    sel = 1'b0;
    show_link = 1'b0;
    mode = marker_mode_e'(s_q.ctrl[CTRL_MODE_LSB +: 2]);
    s_d = s_q;
    ev = '0;

    // recovered line clock copy
    s_d.line_clk = lclk_lvl;

    // frame and multiframe position, advanced per line bit
    // alignment inputs are only trusted in the falling-edge cycle,
    // when the framer has settled them for the bit now starting;
    // a missing alignment simply lets the counts run on
    if (lclk_fall)
    begin
      bit_nx = frame_align_i ? BIT_FIRST : s_q.bit_cnt + BIT_STEP;
      frame_start = (bit_nx == BIT_FIRST);
      if (frame_start)
      begin
        // free-running count when multiframing is off
        sig_nx = (s_q.ctrl[CTRL_SIGMF_EN] && sig_mf_align_i) ? FRM_FIRST : s_q.sig_frm + FRM_STEP;
        crc_nx = (s_q.ctrl[CTRL_CRCMF_EN] && crc_mf_align_i) ? FRM_FIRST : s_q.crc_frm + FRM_STEP;
      end
      sig_start = frame_start && sig_nx == FRM_FIRST;
      crc_start = frame_start && crc_nx == FRM_FIRST;
      s_d.bit_cnt = bit_nx;
      s_d.sig_frm = sig_nx;
      s_d.crc_frm = crc_nx;
      s_d.crc_prev = crc_start;

      // marker, updated only on line clock falling edges
      // composite mode keeps its level between edges; crc_prev remembers
      // that the last bit was crc frame one bit one, so the drop lands
      // on the falling edge that ends that bit
      unique case (mode)
        MARK_FRAME: s_d.marker = frame_start;
        MARK_SIG_MF: s_d.marker = sig_start;
        MARK_CRC_MF: s_d.marker = crc_start;
        MARK_COMPOSITE:
        begin
          // rise at signaling start, drop one bit after crc start
          if (sig_start)
            s_d.marker = 1'b1;
          else if (s_q.crc_prev)
            s_d.marker = 1'b0;
        end
      endcase

      // link bit selection: fractional timeslots or data link bits
      // fractional mode takes whole timeslots from the mask; otherwise
      // timeslot 16 or the chosen national bits of non-alignment frames
      if (s_q.ctrl[CTRL_FRAC_EN])
        sel = s_q.frac[bit_nx[7:3]];
      else
        sel = link_bit_sel(bit_nx, crc_nx[0] == 1'b0, s_q.ctrl[CTRL_SRC_TS16],
                           s_q.ctrl[CTRL_NAT_LSB +: 5]);
      if (sel)
      begin
        // data and link clock fall together
        s_d.link_data = line_bit_i;
        s_d.link_clk = 1'b0;
      end

      // message end clears at the start of the next line bit
      s_d.eom = 1'b0;
    end

    // link clock rises mid-bit for outside sampling
    if (lclk_rise)
      s_d.link_clk = 1'b1;

    // hdlc receiver interrupt, set wins over acknowledge
    // an event in the acknowledge cycle must not be lost
    if (hdlc_irq_ack_i)
      s_d.dl_irq = 1'b0;
    if (hdlc_status_event_i)
      s_d.dl_irq = 1'b1;
    if (hdlc_last_byte_read_i || hdlc_overrun_i)
      s_d.eom = 1'b1;

    // shared pins
    // next values are used so pins follow their source with no extra
    // cycle of lag; the pins are still registered outputs
    show_link = !s_q.ctrl[CTRL_HDLC_EN] || s_q.ctrl[CTRL_FRAC_EN];
    s_d.pin_a = show_link ? s_d.link_data : s_d.dl_irq;
    s_d.pin_b = show_link ? s_d.link_clk : s_d.eom;

    // events
    // strobes last one cycle; the sticky bits live in the irq block
    ev[EV_MARKER] = s_d.marker && !s_q.marker;
    ev[EV_HDLC] = hdlc_status_event_i;
    ev[EV_EOM] = hdlc_last_byte_read_i || hdlc_overrun_i;

    // bus slave: one wait state then answer
    // read data is loaded in the taking cycle and stands while
    // waitrequest is low; writes land at the edge where the master
    // sees waitrequest low, so a held request is applied only once
    s_d.ack = (avs_read_i || avs_write_i) && !s_q.ack;
    if (avs_read_i && !s_q.ack)
    begin
      unique case (avs_address_i)
        OFS_CTRL: s_d.rdata = {19'h0_0000, s_q.ctrl};
        OFS_FRAC: s_d.rdata = s_q.frac;
        OFS_STATUS: s_d.rdata = {29'h0000_0000, ev_status};
        OFS_ENABLE: s_d.rdata = {29'h0000_0000, ev_enable};
        OFS_STATE: s_d.rdata = {15'h0000, s_q.marker, s_q.crc_frm, s_q.sig_frm, s_q.bit_cnt};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_i && s_q.ack)
    begin
      if (avs_address_i == OFS_CTRL)
        s_d.ctrl = CTRL_W'(merge_be({19'h0_0000, s_q.ctrl}, avs_writedata_i, avs_byteenable_i));
      if (avs_address_i == OFS_FRAC)
        s_d.frac = merge_be(s_q.frac, avs_writedata_i, avs_byteenable_i);
    end
  end

  // ==========================================================
  // state register
  // synchronous reset; link clock and message-end pin rest high,
  // control comes up in frame mode with timeslot 16 as link source
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
      s_q.link_clk <= 1'b1;
      s_q.pin_b <= 1'b1;
      s_q.ctrl <= CTRL_RESET;
      s_q.frac <= FRAC_RESET;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs, all from flops
  // only an inverter on waitrequest between state and pins, so outputs carry no glitches
  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = !s_q.ack;
  assign irq_o = ev_irq;
  assign recovered_line_clock_o = s_q.line_clk;
  assign receive_frame_marker_o = s_q.marker;
  assign link_serial_out_o = s_q.pin_a;
  assign link_clock_out_o = s_q.pin_b;
  // marker is unreliable while this is set
  assign line_timing_output_select_o = s_q.ctrl[CTRL_LTSEL];

endmodule : rx_marker_link

`default_nettype wire

// ### sim/rx_marker_link_monitor.sv
// bus, marker and line clock timing assertions for the marker block
`timescale 1ns/1ps
`default_nettype none

module rx_marker_link_monitor
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic line_clock_i,
  input wire logic recovered_line_clock_o,
  input wire logic receive_frame_marker_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========
  // bus handshake
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  // one wait state, then exactly one ready cycle
  a_bus_answer: assert property (s_req |=> s_ack)
    else $error("bus answer late or too long");
  // ready only in answer to a request
  a_bus_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i) || $past(avs_write_i))
    else $error("ready without request");

  // ==========
  // line clock and marker
  a_clk_rise: assert property ($rose(line_clock_i) |-> ##[1:4] recovered_line_clock_o)
    else $error("recovered clock missed a rise");
  a_clk_fall: assert property ($fell(line_clock_i) |-> ##[1:4] !recovered_line_clock_o)
    else $error("recovered clock missed a fall");
  a_marker_rise_low: assert property ($rose(receive_frame_marker_o) |-> (!recovered_line_clock_o) [*8])
    else $error("marker rose away from falling edge");
  a_marker_fall_low: assert property ($fell(receive_frame_marker_o) |-> !recovered_line_clock_o)
    else $error("marker fell away from falling edge");
  a_marker_hold: assert property ($rose(receive_frame_marker_o) |=> receive_frame_marker_o [*8])
    else $error("marker pulse too short");
  a_marker_quiet: assert property ($fell(receive_frame_marker_o) |=> !receive_frame_marker_o [*8])
    else $error("marker gap too short");
endmodule : rx_marker_link_monitor

bind rx_marker_link rx_marker_link_monitor i_rx_marker_link_monitor
(
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .line_clock_i(line_clock_i),
  .recovered_line_clock_o(recovered_line_clock_o),
  .receive_frame_marker_o(receive_frame_marker_o)
);
`default_nettype wire

// ### sim/line_src.sv
// line-side framer source and link data receiver for the marker block
`timescale 1ns/1ps
`default_nettype none

module line_src
(
  input wire logic sig_req_i,
  input wire logic crc_req_i,
  input wire logic link_data_i,
  input wire logic link_clk_i,
  output logic line_clock_o,
  output logic frame_align_o,
  output logic sig_align_o,
  output logic crc_align_o,
  output logic line_bit_o,
  output logic [7:0] link_byte_o
);
  logic [7:0] bit_q = 8'h00;

  // ==========
  // free-running line clock, 125 ns, phase off the bus clock
  initial
  begin
    {frame_align_o, sig_align_o, crc_align_o, line_bit_o} = 4'h0;
    link_byte_o = 8'h00;
    line_clock_o = 1'b1;
    #1;
    forever #62.5 line_clock_o = ~line_clock_o;
  end
  // each falling edge starts a new bit; alignment held for the bit
  always @(negedge line_clock_o)
  begin
    frame_align_o <= (bit_q == 8'h00);
    sig_align_o <= (bit_q == 8'h00) && sig_req_i;
    crc_align_o <= (bit_q == 8'h00) && crc_req_i;
    line_bit_o <= bit_q[0];
    bit_q <= bit_q + 8'h01;
  end
  // link data taken on the rising link clock
  always @(posedge link_clk_i) link_byte_o <= {link_byte_o[6:0], link_data_i};
endmodule : line_src
`default_nettype wire

// ### sim/rx_marker_link_test.sv
// self-checking bench for the receive marker and link output block
`timescale 1ns/1ps
`default_nettype none

module rx_marker_link_test;
  import rx_marker_pkg::*;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [ADDR_W-1:0] adr = 5'h00;
  logic [DATA_W-1:0] wdat = ZERO;
  logic [3:0] hp = 4'h0;
  logic sig_req = 1'b0;
  logic crc_req = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic wreq, irq, rclk, mark, lser, lclk, ltsel, lin_clk, fa, sa, ca, lbit;
  logic [7:0] lbyte;
  logic lclk_q = 1'b1;
  logic mark_q = 1'b0;
  logic [31:0] q;
  int fail_count = 0;
  int num_checks = 0;
  int lrise = 0;
  int mrise = 0;
  int cyc = 0;
  int w;
  int l0;

  // ==========
  // design and line-side model
  rx_marker_link i_rx_marker_link
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .avs_address_i(adr),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq),
    .irq_o(irq),
    .line_clock_i(lin_clk),
    .frame_align_i(fa),
    .sig_mf_align_i(sa),
    .crc_mf_align_i(ca),
    .line_bit_i(lbit),
    .hdlc_status_event_i(hp[0]),
    .hdlc_irq_ack_i(hp[1]),
    .hdlc_last_byte_read_i(hp[2]),
    .hdlc_overrun_i(hp[3]),
    .recovered_line_clock_o(rclk),
    .receive_frame_marker_o(mark),
    .link_serial_out_o(lser),
    .link_clock_out_o(lclk),
    .line_timing_output_select_o(ltsel)
  );
  line_src i_line_src
  (
    .sig_req_i(sig_req),
    .crc_req_i(crc_req),
    .link_data_i(lser),
    .link_clk_i(lclk),
    .line_clock_o(lin_clk),
    .frame_align_o(fa),
    .sig_align_o(sa),
    .crc_align_o(ca),
    .line_bit_o(lbit),
    .link_byte_o(lbyte)
  );

  always #2.5 mclk_i = ~mclk_i;

  // edge counters and run limit
  always @(posedge mclk_i)
  begin
    lclk_q <= lclk;
    mark_q <= mark;
    if (lclk === 1'b1 && lclk_q === 1'b0)
      lrise <= lrise + 1;
    if (mark === 1'b1 && mark_q === 1'b0)
      mrise <= mrise + 1;
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // ==========
  // tasks
  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    #1;
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one bus cycle, held until ready is seen low
  task automatic bus(input logic w_i, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    logic ok;
    int n;
    n = 0;
    ok = 1'b0;
    r = ZERO;
    @(posedge mclk_i);
    rd <= ~w_i;
    wr <= w_i;
    adr <= a;
    wdat <= d;
    // sample ready and read data at the rising edge, before the design updates
    do
    begin
      @(posedge mclk_i);
      ok = (wreq === 1'b0);
      r = rdata;
      n++;
    end
    while (!ok && n < 50);
    rd <= 1'b0;
    wr <= 1'b0;
    if (!ok)
      fail_count++;
    repeat (2) @(posedge mclk_i);
  endtask : bus

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, ZERO, q);
    chk(q, exp);
  endtask : rd_chk

  // width in cycles of the next marker pulse
  task automatic wait_mark(output int n);
    int k;
    n = 0;
    @(negedge mclk_i);
    for (k = 0; k < 7000 && mark !== 1'b1; k++)
      @(negedge mclk_i);
    while (mark === 1'b1 && n < 8000)
    begin
      @(negedge mclk_i);
      n++;
    end
  endtask : wait_mark

  task automatic pulse(input logic [3:0] m);
    @(posedge mclk_i);
    hp <= m;
    @(posedge mclk_i);
    hp <= 4'h0;
    repeat (4) @(posedge mclk_i);
  endtask : pulse

  // ==========
  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd_chk(OFS_CTRL, 32'h0000_0080);
    rd_chk(OFS_FRAC, ZERO);
    rd_chk(OFS_ENABLE, ZERO);
    rd_chk(5'h18, ZERO);
    // frame marker and timeslot 16 link
    wait_mark(w);
    l0 = lrise;
    wait_mark(w);
    chk(w, 25);
    chk(lrise - l0, 8);
    chk(lbyte, 8'h55);
    // signaling multiframe pulse, then a quiet frame
    bus(1'b1, OFS_CTRL, 32'h0000_00A1, q);
    sig_req <= 1'b1;
    wait_mark(w);
    sig_req <= 1'b0;
    chk(w, 25);
    l0 = mrise;
    repeat (7000) @(posedge mclk_i);
    chk(mrise - l0, 0);
    // crc multiframe pulse
    bus(1'b1, OFS_CTRL, 32'h0000_00C2, q);
    crc_req <= 1'b1;
    wait_mark(w);
    crc_req <= 1'b0;
    chk(w, 25);
    // composite, crc frame one a frame after signaling frame one
    bus(1'b1, OFS_CTRL, 32'h0000_00E3, q);
    sig_req <= 1'b1;
    for (w = 0; w < 7000 && sa !== 1'b1; w++)
      @(posedge mclk_i);
    sig_req <= 1'b0;
    crc_req <= 1'b1;
    wait_mark(w);
    chk(w, 6425);
    // composite with coincident boundaries
    sig_req <= 1'b1;
    wait_mark(w);
    sig_req <= 1'b0;
    crc_req <= 1'b0;
    chk(w, 25);
    // receiver status on the shared pins, marker ignored here
    bus(1'b1, OFS_CTRL, 32'h0000_0094, q);
    chk(ltsel, 1'b1);
    bus(1'b1, OFS_CLEAR, 32'h0000_0007, q);
    pulse(4'h1);
    chk(lser, 1'b1);
    bus(1'b1, OFS_ENABLE, 32'h0000_0002, q);
    chk(irq, 1'b1);
    bus(1'b1, OFS_ENABLE, ZERO, q);
    chk(irq, 1'b0);
    bus(1'b1, OFS_ENABLE, 32'h0000_0002, q);
    bus(1'b1, OFS_CLEAR, 32'h0000_0002, q);
    chk(irq, 1'b0);
    pulse(4'h2);
    chk(lser, 1'b0);
    @(negedge rclk);
    pulse(4'h4);
    chk(lclk, 1'b1);
    repeat (30) @(posedge mclk_i);
    chk(lclk, 1'b0);
    @(negedge rclk);
    pulse(4'h8);
    chk(lclk, 1'b1);
    bus(1'b0, OFS_STATUS, ZERO, q);
    chk(q & 32'h0000_0006, 32'h0000_0004);
    stop_test();
  end
endmodule : rx_marker_link_test
`default_nettype wire
